// file: dv/casr_exec_model.sv
/*
  Execution side model: issues one instruction, one watchdog event or both per call.
  Assumes the status bank samples its inputs on the rising edge of mclk.
*/
`timescale 1ns/1ps
module casr_exec_model
  import casr_pkg::*;
(
  input  wire logic               mclk,
  output logic                    instr_valid,
  output casr_kind_t              instr_kind,
  output logic                    instr_to_file,
  output logic      [FADDR_W-1:0] instr_addr,
  output logic      [DATA_W-1:0]  operand_a,
  output logic      [DATA_W-1:0]  operand_b,
  output logic      [DATA_W-1:0]  plain_result,
  output logic                    wdt_timeout
);
  initial begin
    instr_valid   = 1'b0;
    instr_kind    = CASR_K_NONE;
    instr_to_file = 1'b0;
    instr_addr    = 7'h00;
    operand_a     = 8'h00;
    operand_b     = 8'h00;
    plain_result  = 8'h00;
    wdt_timeout   = 1'b0;
  end

  // =====================================================
  // Issue
  task automatic issue(input logic v, input casr_kind_t k, input logic tf, input logic [FADDR_W-1:0] ad,
                       input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
                       input logic [DATA_W-1:0] pr, input logic wdt);
    @(posedge mclk);
    instr_valid   <= v;
    instr_kind    <= k;
    instr_to_file <= tf;
    instr_addr    <= ad;
    operand_a     <= a;
    operand_b     <= b;
    plain_result  <= pr & 8'h3f;
    wdt_timeout   <= wdt;
    @(posedge mclk);
    instr_valid   <= 1'b0;
    wdt_timeout   <= 1'b0;
    // Operand, result and address lines show junk, not a stale copy; kind and to-file lines keep their stale value
    operand_a     <= ~a;
    operand_b     <= ~b;
    plain_result  <= ~pr;
    instr_addr    <= ~ad;
    #1;
  endtask
endmodule // casr_exec_model

// file: dv/tb_cpu_arith_status_register.sv
/*
  Self-checking bench for the status register bank.
  Assumes the execution model drives every instruction input.
*/
`timescale 1ns/1ps
module tb_cpu_arith_status_register
  import casr_pkg::*;
;
  logic mclk, rst_n, iv, tf, wto, rv, db;
  casr_kind_t kd;
  logic [FADDR_W-1:0] ad;
  logic [DATA_W-1:0]  oa, ob, pr, st, rr;
  int num_errors, tests_run;

  casr_exec_model casr_exec_model_i (.mclk(mclk), .instr_valid(iv), .instr_kind(kd), .instr_to_file(tf),
    .instr_addr(ad), .operand_a(oa), .operand_b(ob), .plain_result(pr), .wdt_timeout(wto));
  casr_status casr_status_i (.mclk(mclk), .rst_n(rst_n), .instr_valid(iv), .instr_kind(kd),
    .instr_to_file(tf), .instr_addr(ad), .operand_a(oa), .operand_b(ob), .plain_result(pr),
    .wdt_timeout(wto), .status_reg(st), .result_reg(rr), .result_valid_reg(rv), .dir_bank_reg(db));

  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  // =====================================================
  // Helpers
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic op(input casr_kind_t k, input logic f, input logic [6:0] a7, input logic [7:0] a,
                    input logic [7:0] b, input logic [7:0] p);
    casr_exec_model_i.issue(1'b1, k, f, a7, a, b, p, 1'b0);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // =====================================================
  // Scenarios
  task automatic t_reset();
    chk("status", 8'h18, st);
    chk("bank", 8'h00, {7'h00, db});
  endtask

  task automatic t_plain();
    op(CASR_K_PLAIN, 1'b1, 7'h03, 8'h00, 8'h00, 8'h25);
    chk("status", 8'h3d, st);
    chk("result", 8'h25, rr);
    chk("bank", 8'h01, {7'h00, db});
    op(CASR_K_PLAIN, 1'b1, 7'h04, 8'h00, 8'h00, 8'h00);
    chk("status", 8'h3d, st);
    op(CASR_K_PLAIN, 1'b1, 7'h03, 8'h00, 8'h00, 8'h00);
    chk("status", 8'h18, st);
  endtask

  task automatic t_alu();
    op(CASR_K_ADD, 1'b0, 7'h10, 8'h0f, 8'h01, 8'h00);
    chk("status", 8'h1a, st);
    chk("result", 8'h10, rr);
    chk("valid", 8'h01, {7'h00, rv});
    op(CASR_K_ADD, 1'b0, 7'h10, 8'hff, 8'h01, 8'h00);
    chk("status", 8'h1f, st);
    op(CASR_K_SUB, 1'b0, 7'h10, 8'h05, 8'h03, 8'h00);
    chk("status", 8'h1b, st);
    op(CASR_K_SUB, 1'b0, 7'h10, 8'h03, 8'h05, 8'h00);
    chk("status", 8'h18, st);
    chk("result", 8'hfe, rr);
  endtask

  task automatic t_dest();
    op(CASR_K_ADD, 1'b1, 7'h03, 8'h20, 8'h05, 8'h00);
    chk("status", 8'h38, st);
    op(CASR_K_SUB, 1'b0, 7'h10, 8'h05, 8'h03, 8'h00);
    op(CASR_K_CLEAR, 1'b1, 7'h03, 8'h00, 8'h00, 8'h00);
    chk("status", 8'h1f, st);
    chk("result", 8'h00, rr);
    op(CASR_K_LOGIC, 1'b0, 7'h10, 8'h00, 8'h00, 8'h01);
    chk("status", 8'h1b, st);
  endtask

  task automatic t_events();
    casr_exec_model_i.issue(1'b0, CASR_K_NONE, 1'b0, 7'h10, 8'h00, 8'h00, 8'h00, 1'b1);
    chk("status", 8'h0b, st);
    op(CASR_K_SLEEP, 1'b0, 7'h10, 8'h00, 8'h00, 8'h00);
    chk("status", 8'h13, st);
    op(CASR_K_KICK, 1'b0, 7'h10, 8'h00, 8'h00, 8'h00);
    chk("status", 8'h1b, st);
    chk("valid", 8'h00, {7'h00, rv});
    casr_exec_model_i.issue(1'b1, CASR_K_SLEEP, 1'b0, 7'h10, 8'h00, 8'h00, 8'h00, 1'b1);
    chk("status", 8'h03, st);
  endtask

  // =====================================================
  // Main sequence and watchdog
  initial begin
    num_errors = 0;
    tests_run = 0;
    rst_n = 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    t_reset();
    t_plain();
    t_alu();
    t_dest();
    t_events();
    // Mid-run reset must bring back the power-on value
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    t_reset();
    conclude();
  end

  // Whole run needs under 60 cycles
  initial begin
    #(400 * 50);
    num_errors++;
    conclude();
  end
endmodule // tb_cpu_arith_status_register

// file: rtl/casr_flag_calc.sv
/*
  Combinational adder/subtractor with carry and nibble carry flags; the caller forms the zero flag.
  Assumes operands are registered or stable in the caller's clock domain.
*/
`timescale 1ns/1ps
module casr_flag_calc
  import casr_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W
) (
  input  wire logic [WIDTH-1:0] op_a,
  input  wire logic [WIDTH-1:0] op_b,
  input  wire logic             subtract,
  output logic      [WIDTH-1:0] sum,
  output logic                  carry_out,
  output logic                  nib_carry_out
);

  // Refused at elaboration: no nibble carry without a bit above the nibble
  if (WIDTH <= NIBBLE_MSB + 1) begin : g_width_check
    $error("casr_flag_calc: WIDTH too small for a nibble carry");
  end

  logic [WIDTH-1:0] b_eff;
  logic [WIDTH:0]   full;
  logic [NIBBLE_MSB+1:0] low;

  // Subtraction as a + ~b + 1, so carry means no borrow
  assign b_eff = subtract ? ~op_b : op_b;
  assign full  = {1'b0, op_a} + {1'b0, b_eff} + {{WIDTH{1'b0}}, subtract};
  assign low   = {1'b0, op_a[NIBBLE_MSB:0]} + {1'b0, b_eff[NIBBLE_MSB:0]}
               + {{(NIBBLE_MSB+1){1'b0}}, subtract};

  assign sum           = full[WIDTH-1:0];
  assign carry_out     = full[WIDTH];
  assign nib_carry_out = low[NIBBLE_MSB+1];

endmodule // casr_flag_calc

// file: rtl/casr_pkg.sv
/*
  Constants and types shared by the status register bank and its flag
  calculator. Assumes an 8-bit data path and a 7-bit direct file address.
*/
package casr_pkg;

  localparam int unsigned DATA_W      = 8;
  localparam int unsigned FADDR_W     = 7;
  localparam int unsigned BANK_ADDR_W = 8;

  // Register locations, one physical register seen from both banks
  localparam logic [BANK_ADDR_W-1:0] STAT_ADDR_BANK0 = 8'h03;
  localparam logic [BANK_ADDR_W-1:0] STAT_ADDR_BANK1 = 8'h83;

  // Field positions
  localparam int unsigned IND_BANK_BIT  = 7;
  localparam int unsigned DIR_HI_BIT    = 6;
  localparam int unsigned DIR_LO_BIT    = 5;
  localparam int unsigned WDT_FLAG_BIT  = 4;
  localparam int unsigned SLP_FLAG_BIT  = 3;
  localparam int unsigned ZERO_BIT      = 2;
  localparam int unsigned NIB_CARRY_BIT = 1;
  localparam int unsigned CARRY_BIT     = 0;
  localparam int unsigned NIBBLE_MSB    = 3;

  // Reset value: bank selects low, both reset flags high, arithmetic flags zero
  localparam logic [DATA_W-1:0] STAT_RESET = 8'h18;

  typedef enum logic [2:0] {
    CASR_K_NONE  = 3'h0,
    CASR_K_ADD   = 3'h1,
    CASR_K_SUB   = 3'h2,
    CASR_K_LOGIC = 3'h3,
    CASR_K_CLEAR = 3'h4,
    CASR_K_PLAIN = 3'h5,
    CASR_K_KICK  = 3'h6,
    CASR_K_SLEEP = 3'h7
  } casr_kind_t;

endpackage : casr_pkg

// file: rtl/casr_status.sv
/*
  Processor status register: arithmetic flags, reset cause flags and bank
  selects, updated by the instruction execution logic one instruction a cycle.
  Assumes all inputs come from core logic on mclk; no pin is sampled here.
*/
`timescale 1ns/1ps

// How it works
// - Status register accepted as any instruction destination
// - Flag-affecting ops ignore written zero/carry bits
// - Writes never change the two reset flags
// - Clear clears upper three, sets zero flag
// - Plain moves, bit ops, swap write verbatim
// - Subtraction carries are inverted borrow indicators
// - Reachable at 03h and mirrored at 83h
// - Nibble carry from bit three on add/sub
// - Timeout clears watchdog flag; kick, sleep set it
// - Sleep clears sleep flag; kick sets it
// - Zero flag tracks zero result on add, sub, logic and clear
// - Carry from most significant bit on add/sub
module casr_status
  import casr_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic               instr_valid,
  input  wire casr_kind_t         instr_kind,
  input  wire logic               instr_to_file,
  input  wire logic [FADDR_W-1:0] instr_addr,
  input  wire logic [DATA_W-1:0]  operand_a,
  input  wire logic [DATA_W-1:0]  operand_b,
  input  wire logic [DATA_W-1:0]  plain_result,
  input  wire logic               wdt_timeout,
  output logic      [DATA_W-1:0]  status_reg,
  output logic      [DATA_W-1:0]  result_reg,
  output logic                    result_valid_reg,
  output logic                    dir_bank_reg
);

  // ==========================================================
  // Decode helpers
  // ==========================================================
  function automatic logic hits_status(input logic bank, input logic [FADDR_W-1:0] addr);
    logic [BANK_ADDR_W-1:0] full;
    full = {bank, addr};
    return (full == STAT_ADDR_BANK0) || (full == STAT_ADDR_BANK1);
  endfunction

  function automatic logic sets_flags(input casr_kind_t k);
    return (k == CASR_K_ADD) || (k == CASR_K_SUB) || (k == CASR_K_LOGIC) || (k == CASR_K_CLEAR);
  endfunction

  // ==========================================================
  // Arithmetic
  // ==========================================================
  logic [DATA_W-1:0] alu_sum;
  logic              alu_carry;
  logic              alu_nib_carry;

  casr_flag_calc #(
    .WIDTH (DATA_W)
  ) u_calc (
    .op_a          (operand_a),
    .op_b          (operand_b),
    .subtract      (instr_kind == CASR_K_SUB),
    .sum           (alu_sum),
    .carry_out     (alu_carry),
    .nib_carry_out (alu_nib_carry)
  );

  // ==========================================================
  // Next value
  // ==========================================================
  logic [DATA_W-1:0] result_next;
  logic [DATA_W-1:0] status_next;
  logic              hit;

  assign hit = instr_valid && instr_to_file && hits_status(status_reg[DIR_LO_BIT], instr_addr);

  always_comb begin
    status_next = status_reg;
    result_next = plain_result;
    if (instr_valid) begin
      case (instr_kind)
        CASR_K_ADD, CASR_K_SUB: begin
          result_next                = alu_sum;
          status_next[CARRY_BIT]     = alu_carry;
          status_next[NIB_CARRY_BIT] = alu_nib_carry;
          status_next[ZERO_BIT]      = (alu_sum == '0);
        end
        CASR_K_LOGIC: begin
          status_next[ZERO_BIT] = (plain_result == '0);
        end
        CASR_K_CLEAR: begin
          result_next           = '0;
          status_next[ZERO_BIT] = 1'b1;
        end
        CASR_K_KICK: begin
          status_next[WDT_FLAG_BIT] = 1'b1;
          status_next[SLP_FLAG_BIT] = 1'b1;
        end
        CASR_K_SLEEP: begin
          status_next[WDT_FLAG_BIT] = 1'b1;
          status_next[SLP_FLAG_BIT] = 1'b0;
        end
        default: begin
        end
      endcase
      if (hit) begin
        // Bank bits always take the result; upper two are kept zero by software
        status_next[IND_BANK_BIT:DIR_LO_BIT] = result_next[IND_BANK_BIT:DIR_LO_BIT];
        if (!sets_flags(instr_kind)) begin
          status_next[ZERO_BIT:CARRY_BIT] = result_next[ZERO_BIT:CARRY_BIT];
        end
        // Reset flags are left out of the write on purpose
      end
    end
    // Watchdog expiry beats a kick in the same cycle, the reset is coming
    if (wdt_timeout) begin
      status_next[WDT_FLAG_BIT] = 1'b0;
    end
  end

  // ==========================================================
  // State
  // ==========================================================
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= STAT_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dir_bank_reg <= 1'b0;
    end else begin
      dir_bank_reg <= status_next[DIR_LO_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result_reg       <= '0;
      result_valid_reg <= 1'b0;
    end else begin
      result_reg       <= result_next;
      result_valid_reg <= instr_valid && (instr_kind != CASR_K_NONE) && (instr_kind != CASR_K_KICK)
                          && (instr_kind != CASR_K_SLEEP);
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  chk_clear_status: assert property (@(posedge mclk) disable iff (!rst_n)
    (instr_valid && instr_kind == CASR_K_CLEAR && hit && !wdt_timeout) |=>
      (status_reg[IND_BANK_BIT:DIR_LO_BIT] == 3'h0) && status_reg[ZERO_BIT]
      && (status_reg[WDT_FLAG_BIT:SLP_FLAG_BIT] == $past(status_reg[WDT_FLAG_BIT:SLP_FLAG_BIT]))
      && (status_reg[NIB_CARRY_BIT:CARRY_BIT] == $past(status_reg[NIB_CARRY_BIT:CARRY_BIT])))
    else $error("clear of status register gave wrong bits");

  chk_reset_flags_held: assert property (@(posedge mclk) disable iff (!rst_n)
    (instr_valid && hit && instr_kind inside {CASR_K_PLAIN, CASR_K_ADD, CASR_K_SUB, CASR_K_LOGIC, CASR_K_CLEAR}
      && !wdt_timeout) |=>
      status_reg[WDT_FLAG_BIT:SLP_FLAG_BIT] == $past(status_reg[WDT_FLAG_BIT:SLP_FLAG_BIT]))
    else $error("write changed a reset flag");

  chk_flag_write_blocked: assert property (@(posedge mclk) disable iff (!rst_n)
    (instr_valid && hit && instr_kind == CASR_K_ADD) |=>
      status_reg[CARRY_BIT] == $past(alu_carry) && status_reg[NIB_CARRY_BIT] == $past(alu_nib_carry))
    else $error("written value overrode arithmetic flags");

  chk_plain_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (instr_valid && hit && instr_kind == CASR_K_PLAIN) |=>
      status_reg[IND_BANK_BIT:DIR_LO_BIT] == $past(plain_result[IND_BANK_BIT:DIR_LO_BIT])
      && status_reg[ZERO_BIT:CARRY_BIT] == $past(plain_result[ZERO_BIT:CARRY_BIT]))
    else $error("plain write not taken as commanded");

  chk_mirror_hit: assert property (@(posedge mclk) disable iff (!rst_n)
    (instr_valid && instr_to_file && instr_kind == CASR_K_PLAIN && instr_addr == STAT_ADDR_BANK0[FADDR_W-1:0])
      |=> status_reg[ZERO_BIT:CARRY_BIT] == $past(plain_result[ZERO_BIT:CARRY_BIT]))
    else $error("status not reached from both banks");

  chk_sleep_flags: assert property (@(posedge mclk) disable iff (!rst_n)
    (instr_valid && instr_kind == CASR_K_SLEEP && !wdt_timeout) |=>
      status_reg[WDT_FLAG_BIT] && !status_reg[SLP_FLAG_BIT] ##1 1'b1)
    else $error("sleep did not set reset flags right");

  chk_timeout_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    wdt_timeout |=> !status_reg[WDT_FLAG_BIT])
    else $error("watchdog expiry did not clear its flag");

  chk_kick_flags: assert property (@(posedge mclk) disable iff (!rst_n)
    (instr_valid && instr_kind == CASR_K_KICK && !wdt_timeout) |=>
      status_reg[WDT_FLAG_BIT] && status_reg[SLP_FLAG_BIT])
    else $error("kick did not set both reset flags");

  chk_logic_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    (instr_valid && instr_kind == CASR_K_LOGIC) |=>
      status_reg[ZERO_BIT] == ($past(plain_result) == 8'h00))
    else $error("logic op zero flag wrong");

  chk_clear_result: assert property (@(posedge mclk) disable iff (!rst_n)
    (instr_valid && instr_kind == CASR_K_CLEAR) |=>
      (result_reg == 8'h00) && result_valid_reg)
    else $error("clear did not give a zero result");

  chk_sub_borrow: assert property (@(posedge mclk) disable iff (!rst_n)
    (instr_valid && instr_kind == CASR_K_SUB && !hit) |=>
      status_reg[CARRY_BIT] == ($past(operand_a) >= $past(operand_b))
      && status_reg[NIB_CARRY_BIT] == ($past(operand_a[NIBBLE_MSB:0]) >= $past(operand_b[NIBBLE_MSB:0])))
    else $error("borrow polarity wrong in subtraction");

  chk_add_flags: assert property (@(posedge mclk) disable iff (!rst_n)
    (instr_valid && instr_kind == CASR_K_ADD && !hit) |=>
      status_reg[ZERO_BIT] == (8'($past(operand_a) + $past(operand_b)) == 8'h00)
      && status_reg[NIB_CARRY_BIT] == ({1'b0, $past(operand_a[NIBBLE_MSB:0])}
                                       + {1'b0, $past(operand_b[NIBBLE_MSB:0])} > 5'h0f)
      && status_reg[CARRY_BIT] == ({1'b0, $past(operand_a)} + {1'b0, $past(operand_b)} > 9'h0ff))
    else $error("add flags wrong");

  chk_bank_out: assert property (@(posedge mclk) disable iff (!rst_n)
    dir_bank_reg == status_reg[DIR_LO_BIT])
    else $error("bank output out of step with register");

endmodule // casr_status
